// [src/sscs_consts.svh]
/*
  Constants of the strap configuration and clock select block: register
  addresses, field positions, reset values and watchdog timing.
  Assumes it is included by its bare name after the package.
*/
`ifndef SSCS_CONSTS_SVH
`define SSCS_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses (low 7 bits of the address byte)
// ----------------------------------------------------------------
`define SSCS_ADDR_GLOBAL 7'h00
`define SSCS_ADDR_CURRENT 7'h10
`define SSCS_ADDR_PWRDN 7'h11
`define SSCS_ADDR_VLIMIT 7'h13
`define SSCS_ADDR_CHOP 7'h6C
`define SSCS_WRITE_BIT 39

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSCS_GC_QUIET 2
`define SSCS_GC_ERRDIAG 5
`define SSCS_GC_IDXDIAG 6
`define SSCS_CH_OFF_TIME 3:0
`define SSCS_CH_RESOLUTION 27:24
`define SSCS_CU_HOLD 4:0
`define SSCS_CU_RUN 12:8
`define SSCS_CU_DELAY 19:16

// ----------------------------------------------------------------
// Reset values and strap decode values
// ----------------------------------------------------------------
`define SSCS_RST_GLOBAL 32'h0000_0000
`define SSCS_RST_CHOP 32'h0000_0000
`define SSCS_RST_CURRENT 32'h0000_0000
`define SSCS_RST_PWRDN 32'h0000_0000
`define SSCS_RST_VLIMIT 32'h0000_0000
`define SSCS_RES_CODE_8 4'h5
`define SSCS_RUN_BASE 5'h10
`define SSCS_RUN_MAX 5'h1F
`define SSCS_OFF_TIME_STANDALONE 4'h3

// ----------------------------------------------------------------
// Clock watchdog: internal oscillator cycles without an external edge
// ----------------------------------------------------------------
`define SSCS_WDOG_CYCLES 6'h20

`endif

// [src/sscs_pkg.sv]
/*
  Types of the strap configuration and clock select block.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package sscs_pkg;

  typedef enum logic [1:0] {
    SSCS_CLK_INT = 2'b01,
    SSCS_CLK_EXT = 2'b10
  } sscs_clk_e;

  typedef struct packed {
    logic iface_select;
    logic stepdir_select;
    logic [6:0] cfg;
    logic ext_clk;
  } sscs_pins_s;

  typedef struct packed {
    logic standalone;
    logic serial_enable;
    logic single_wire_enable;
    logic error_on_first_diag;
    logic index_on_second_diag;
    logic quiet_chopper_enable;
    logic [3:0] microstep_resolution_code;
    logic [4:0] run_current_scale;
    logic [4:0] hold_current_scale;
    logic [3:0] hold_ramp_delay;
    logic [3:0] chopper_off_time;
  } sscs_config_s;

  typedef struct packed {
    sscs_pins_s sync1;
    sscs_pins_s sync2;
    logic ext_prev;
    logic [1:0] ext_edges;
    logic [5:0] wdog;
    sscs_clk_e clk_src;
    logic [31:0] global_configuration;
    logic [31:0] chopper_configuration;
    logic [31:0] motor_current_settings;
    logic [31:0] powerdown_delay;
    logic [31:0] quiet_mode_velocity_limit;
    sscs_config_s cfg;
  } sscs_state_s;

endpackage

`default_nettype wire

// [src/sscs_top.sv]
/*
  Configuration front end of a stepper driver: standalone strap decode,
  serial register writes with power-on defaults, and clock source select
  with a watchdog. Assumes straps and the external clock are asynchronous
  pins and that the serial datagram port is driven on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sscs_consts.svh"

// Notes on behaviour
// - Standalone when interface select strap is low and step/dir strap high.
// - Standalone turns off serial and single wire interfaces; step/dir only.
// - Standalone forces error reporting on the first diagnostic output.
// - Standalone forces index reporting on the second diagnostic output.
// - Resolution straps pick 8, 16, 32, 64 microsteps: codes 5, 4, 3, 2.
// - Current straps n give run current 16+2n, or 31 when all high.
// - Chopper strap low gives off-time 3; high enables quiet chopper.
// - Hold strap low: hold equals run; high: hold is half of run.
// - Internal oscillator is used while no external clock is detected.
// - Switch to the external clock only on its second rising edge.
// - Watchdog returns to internal clock after about 32 cycles without edges.
// - Power-on reset loads defaults into all configuration registers.
module sscs_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic interface_select_strap,
  input wire logic stepdir_select_strap,
  input wire logic strap_resolution_lsb,
  input wire logic strap_resolution_msb,
  input wire logic strap_current_bit0,
  input wire logic strap_current_bit1,
  input wire logic strap_current_bit2,
  input wire logic strap_chopper_select,
  input wire logic strap_hold_reduction,
  input wire logic ext_clk_pin,
  input wire logic dgram_valid,
  input wire logic [39:0] dgram,
  output sscs_pkg::sscs_config_s config_out,
  output logic use_ext_clk,
  output logic [31:0] powerdown_delay,
  output logic [31:0] quiet_mode_velocity_limit
);
  import sscs_pkg::*;

  sscs_state_s st;
  sscs_state_s next_st;
  sscs_pins_s pins;
  logic standalone;
  logic [2:0] cur_n;
  logic [6:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_en;
  sscs_config_s sa_cfg;
  sscs_config_s reg_cfg;

  assign pins = '{iface_select: interface_select_strap,
                  stepdir_select: stepdir_select_strap,
                  cfg: {strap_hold_reduction, strap_chopper_select, strap_current_bit2,
                        strap_current_bit1, strap_current_bit0, strap_resolution_msb,
                        strap_resolution_lsb},
                  ext_clk: ext_clk_pin};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    standalone = !st.sync2.iface_select && st.sync2.stepdir_select;
    cur_n = st.sync2.cfg[4:2];
    wr_addr = dgram[38:32];
    wr_data = dgram[31:0];
    // Writes are dropped in standalone since the serial port is off
    wr_en = dgram_valid && dgram[`SSCS_WRITE_BIT] && !standalone;

    // Clock source: count rising edges, watchdog on the gap between them
    next_st.ext_prev = st.sync2.ext_clk;
    if (st.sync2.ext_clk && !st.ext_prev) begin
      next_st.wdog = 6'h00;
      if (st.ext_edges != 2'h2) begin
        next_st.ext_edges = st.ext_edges + 2'h1;
      end
      if (st.ext_edges == 2'h1) begin
        next_st.clk_src = SSCS_CLK_EXT;
      end
    end else if (st.wdog > `SSCS_WDOG_CYCLES) begin
      // A held-low pin never reaches two edges and stays internal
      next_st.clk_src = SSCS_CLK_INT;
      next_st.ext_edges = 2'h0;
    end else begin
      // Stops one past the limit and parks there, so it never wraps
      next_st.wdog = st.wdog + 6'h01;
    end

    if (wr_en) begin
      unique case (wr_addr)
        `SSCS_ADDR_GLOBAL: next_st.global_configuration = wr_data;
        `SSCS_ADDR_CHOP: next_st.chopper_configuration = wr_data;
        `SSCS_ADDR_CURRENT: next_st.motor_current_settings = wr_data;
        `SSCS_ADDR_PWRDN: next_st.powerdown_delay = wr_data;
        `SSCS_ADDR_VLIMIT: next_st.quiet_mode_velocity_limit = wr_data;
        default: next_st.global_configuration = st.global_configuration;
      endcase
    end

    // Strap decode
    sa_cfg.standalone = 1'b1;
    sa_cfg.serial_enable = 1'b0;
    sa_cfg.single_wire_enable = 1'b0;
    sa_cfg.error_on_first_diag = 1'b1;
    sa_cfg.index_on_second_diag = 1'b1;
    sa_cfg.microstep_resolution_code =
      `SSCS_RES_CODE_8 - {2'b00, st.sync2.cfg[1:0]};
    sa_cfg.run_current_scale = (cur_n == 3'h7) ? `SSCS_RUN_MAX :
      `SSCS_RUN_BASE + {1'b0, cur_n, 1'b0};
    sa_cfg.quiet_chopper_enable = st.sync2.cfg[5];
    sa_cfg.chopper_off_time = st.sync2.cfg[5] ? st.chopper_configuration[`SSCS_CH_OFF_TIME] :
      `SSCS_OFF_TIME_STANDALONE;
    sa_cfg.hold_current_scale = st.sync2.cfg[6] ? {1'b0, sa_cfg.run_current_scale[4:1]} :
      sa_cfg.run_current_scale;
    // No strap sets the hold ramp, so it keeps the register value
    sa_cfg.hold_ramp_delay = st.motor_current_settings[`SSCS_CU_DELAY];

    reg_cfg.standalone = 1'b0;
    reg_cfg.serial_enable = 1'b1;
    reg_cfg.single_wire_enable = 1'b1;
    reg_cfg.error_on_first_diag = st.global_configuration[`SSCS_GC_ERRDIAG];
    reg_cfg.index_on_second_diag = st.global_configuration[`SSCS_GC_IDXDIAG];
    reg_cfg.quiet_chopper_enable = st.global_configuration[`SSCS_GC_QUIET];
    reg_cfg.microstep_resolution_code = st.chopper_configuration[`SSCS_CH_RESOLUTION];
    reg_cfg.run_current_scale = st.motor_current_settings[`SSCS_CU_RUN];
    reg_cfg.hold_current_scale = st.motor_current_settings[`SSCS_CU_HOLD];
    reg_cfg.hold_ramp_delay = st.motor_current_settings[`SSCS_CU_DELAY];
    reg_cfg.chopper_off_time = st.chopper_configuration[`SSCS_CH_OFF_TIME];

    next_st.cfg = standalone ? sa_cfg : reg_cfg;
  end

  // ----------------------------------------------------------------
  // State register; reset stands for the power-on reset
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.clk_src <= SSCS_CLK_INT;
      st.global_configuration <= `SSCS_RST_GLOBAL;
      st.chopper_configuration <= `SSCS_RST_CHOP;
      st.motor_current_settings <= `SSCS_RST_CURRENT;
      st.powerdown_delay <= `SSCS_RST_PWRDN;
      st.quiet_mode_velocity_limit <= `SSCS_RST_VLIMIT;
      // Serial ports read as enabled until the straps have been sampled
      st.cfg.serial_enable <= 1'b1;
      st.cfg.single_wire_enable <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign config_out = st.cfg;
  // One-hot source code: bit 1 marks the external clock, so no gate sits on the output
  assign use_ext_clk = st.clk_src[1];
  assign powerdown_delay = st.powerdown_delay;
  assign quiet_mode_velocity_limit = st.quiet_mode_velocity_limit;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Strap checks look one edge back, since config_out is registered

  a_standalone_entry: assert property (##1 st.cfg.standalone ==
    $past(!st.sync2.iface_select && st.sync2.stepdir_select))
    else $error("standalone flag does not follow mode straps");
  a_serial_off: assert property (st.cfg.standalone |->
    !st.cfg.serial_enable && !st.cfg.single_wire_enable)
    else $error("serial interfaces on in standalone");
  a_diag_error: assert property (st.cfg.standalone |-> st.cfg.error_on_first_diag)
    else $error("first diag not forced to error");
  a_diag_index: assert property (st.cfg.standalone |-> st.cfg.index_on_second_diag)
    else $error("second diag not forced to index");
  a_microstep_resolution_code_map: assert property (##1 st.cfg.standalone |-> st.cfg.microstep_resolution_code ==
    4'h5 - {2'b00, $past(st.sync2.cfg[1:0])})
    else $error("resolution code wrong");
  a_run_current_scale_map: assert property (##1 st.cfg.standalone |-> st.cfg.run_current_scale ==
    (($past(st.sync2.cfg[4:2]) == 3'd7) ? 5'h1F :
     5'h10 + {1'b0, $past(st.sync2.cfg[4:2]), 1'b0}))
    else $error("run current wrong");
  a_chop_mode: assert property (##1 st.cfg.standalone && !$past(st.sync2.cfg[5]) |->
    st.cfg.chopper_off_time == 4'h3 && !st.cfg.quiet_chopper_enable)
    else $error("chopper strap decode wrong");
  a_hold_half: assert property (##1 st.cfg.standalone |-> st.cfg.hold_current_scale ==
    ($past(st.sync2.cfg[6]) ? {1'b0, st.cfg.run_current_scale[4:1]} :
     st.cfg.run_current_scale))
    else $error("hold current wrong");
  a_int_no_edges: assert property (st.ext_edges == 2'h0 |=> !use_ext_clk ||
    $past(use_ext_clk))
    else $error("external clock chosen without edges");
  a_second_edge: assert property ($rose(use_ext_clk) |-> $past(st.ext_edges) == 2'h1)
    else $error("switch not on second edge");
  a_watchdog: assert property (st.wdog > `SSCS_WDOG_CYCLES && !(st.sync2.ext_clk && !st.ext_prev)
    |=> !use_ext_clk)
    else $error("watchdog did not fall back");
  a_write_reg: assert property (wr_en && wr_addr == `SSCS_ADDR_CHOP |=>
    st.chopper_configuration == $past(wr_data))
    else $error("chopper write lost");
  a_reg_apply: assert property (##1 !st.cfg.standalone |->
    st.cfg.run_current_scale == $past(st.motor_current_settings[12:8]))
    else $error("register value not applied");

  // Main scenarios the bench is expected to reach
  c_standalone: cover property (st.cfg.standalone && st.cfg.quiet_chopper_enable);
  c_ext_switch: cover property ($rose(use_ext_clk));
  c_fallback: cover property ($fell(use_ext_clk));
  c_write: cover property (wr_en);

endmodule

`default_nettype wire

// [bench/sscs_host_model.sv]
/*
  Far-side model: the serial host that writes datagrams and the external
  clock source. Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
`default_nettype none
module sscs_host_model (
  input wire logic sys_clk,
  output logic dgram_valid,
  output logic [39:0] dgram,
  output logic ext_clk_pin
);
  initial begin
    dgram_valid = 1'b0;
    dgram = 40'h00_0000_0000;
    ext_clk_pin = 1'b0;
  end
  // One whole datagram, valid for exactly one edge
  task automatic send(input logic [39:0] word);
    @(posedge sys_clk);
    dgram_valid <= 1'b1;
    dgram <= word;
    @(posedge sys_clk);
    dgram_valid <= 1'b0;
    dgram <= ~word;
  endtask
  // Example bring-up order; the motor stays at rest meanwhile
  task automatic setup;
    send(40'hEC000100C3);
    send(40'h9000061F0A);
    send(40'h910000000A);
    send(40'h8000000004);
    send(40'h93000001F4);
  endtask
  // Slow pulses so the two-stage sync chain sees every edge
  task automatic clock_out(input int n);
    repeat (n) begin
      repeat (3) @(posedge sys_clk);
      ext_clk_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ext_clk_pin <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
/*
  Self-checking bench for the strap configuration and clock select block.
  Assumes the host model drives datagrams and the external clock pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sscs_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic iface = 1'b1;
  logic stepdir = 1'b1;
  logic [6:0] s = 7'h00;
  logic dgram_valid;
  logic ext_clk_pin;
  logic [39:0] dgram;
  sscs_config_s c;
  logic use_ext;
  logic [31:0] pd;
  logic [31:0] vl;
  int error_cnt = 0;
  int n_compared = 0;
  always #25 sys_clk = ~sys_clk;
  sscs_host_model host (.sys_clk(sys_clk), .dgram_valid(dgram_valid), .dgram(dgram),
    .ext_clk_pin(ext_clk_pin));
  sscs_top dut (.sys_clk(sys_clk), .reset(reset), .interface_select_strap(iface),
    .stepdir_select_strap(stepdir), .strap_resolution_lsb(s[0]), .strap_resolution_msb(s[1]),
    .strap_current_bit0(s[2]), .strap_current_bit1(s[3]), .strap_current_bit2(s[4]),
    .strap_chopper_select(s[5]), .strap_hold_reduction(s[6]), .ext_clk_pin(ext_clk_pin),
    .dgram_valid(dgram_valid), .dgram(dgram), .config_out(c), .use_ext_clk(use_ext),
    .powerdown_delay(pd), .quiet_mode_velocity_limit(vl));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Tables follow the strap decode rules, not the design's arithmetic
  function automatic logic [4:0] exp_run(input logic [2:0] n);
    case (n)
      3'h0: return 5'h10;
      3'h1: return 5'h12;
      3'h2: return 5'h14;
      3'h3: return 5'h16;
      3'h4: return 5'h18;
      3'h5: return 5'h1A;
      3'h6: return 5'h1C;
      default: return 5'h1F;
    endcase
  endfunction
  function automatic logic [3:0] exp_res(input logic [1:0] sel);
    case (sel)
      2'h0: return 4'h5;
      2'h1: return 4'h4;
      2'h2: return 4'h3;
      default: return 4'h2;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // Sample one step after the edge so design updates have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [6:0] v;
    logic [4:0] r;
    void'($urandom(32'h120A));
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    wait_cyc(40);
    chk(use_ext, 1'b0, "pin low");
    host.clock_out(1);
    wait_cyc(3);
    chk(use_ext, 1'b0, "one edge");
    host.clock_out(1);
    wait_cyc(3);
    chk(use_ext, 1'b1, "two edges");
    wait_cyc(20);
    chk(use_ext, 1'b1, "clock held");
    wait_cyc(20);
    chk(use_ext, 1'b0, "clock lost");
    $display("test clock_select done");
    host.setup();
    host.send(40'hFF00000000);
    host.send(40'h1000000000);
    wait_cyc(3);
    chk(c.standalone, 1'b0, "standalone");
    chk(c.serial_enable, 1'b1, "serial on");
    chk(c.error_on_first_diag, 1'b0, "err diag");
    chk(c.run_current_scale, 5'h1F, "reg run");
    chk(c.hold_current_scale, 5'h0A, "reg hold");
    chk(c.hold_ramp_delay, 4'h6, "reg delay");
    chk(c.chopper_off_time, 4'h3, "reg chopper_off_time");
    chk(c.quiet_chopper_enable, 1'b1, "reg quiet");
    chk({c.index_on_second_diag, c.microstep_resolution_code}, 5'h00, "reg idx microstep_resolution_code");
    chk(pd, 32'h0000_000A, "powerdown");
    chk(vl, 32'h0000_01F4, "vlimit");
    $display("test serial done");
    for (int i = 0; i < 16; i++) begin
      v = 7'($urandom());
      v[4:2] = 3'(i);
      v[1:0] = 2'(i);
      if (i == 0) v[6:5] = 2'h0;
      if (i == 15) v = 7'h7F;
      r = exp_run(v[4:2]);
      @(posedge sys_clk);
      iface <= 1'b0;
      s <= v;
      wait_cyc(4);
      chk(c.standalone, 1'b1, "standalone");
      chk({c.serial_enable, c.single_wire_enable}, 2'b00, "ifaces");
      chk(c.error_on_first_diag, 1'b1, "err diag");
      chk(c.index_on_second_diag, 1'b1, "idx diag");
      chk(c.microstep_resolution_code, exp_res(v[1:0]), "microstep_resolution_code");
      chk(c.run_current_scale, r, "run");
      chk(c.quiet_chopper_enable, v[5], "quiet");
      if (!v[5]) chk(c.chopper_off_time, 4'h3, "chopper_off_time");
      chk(c.hold_current_scale, v[6] ? r >> 1 : r, "hold");
    end
    host.send(40'h9100000055);
    wait_cyc(3);
    chk(pd, 32'h0000_000A, "write in standalone");
    $display("test standalone done");
    @(posedge sys_clk);
    reset <= 1'b1;
    wait_cyc(2);
    chk(pd | vl, 32'h0000_0000, "reset regs");
    chk({c.standalone, c.serial_enable, use_ext}, 3'b010, "reset cfg");
    @(posedge sys_clk);
    reset <= 1'b0;
    $display("test reset done");
    complete_run();
  end
  initial begin
    #100000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
endmodule
`default_nettype wire
